// *** core/ddac_pkg.sv ***
// package: register map, field positions and reset values of the dual converter control block
package ddac_pkg;
  localparam logic [7:0] DDAC_OFS_CH0_LOW  = 8'hF9;
  localparam logic [7:0] DDAC_OFS_CH0_HIGH = 8'hFA;
  localparam logic [7:0] DDAC_OFS_CH1_LOW  = 8'hFB;
  localparam logic [7:0] DDAC_OFS_CH1_HIGH = 8'hFC;
  localparam logic [7:0] DDAC_OFS_CONTROL  = 8'hFD;
  localparam logic [7:0] DDAC_OFS_SYSCFG   = 8'hAF;
  localparam logic [7:0] DDAC_OFS_STATUS   = 8'hF8;

  localparam logic [7:0] DDAC_CONTROL_RST  = 8'h04;
  localparam logic [7:0] DDAC_CODE_RST     = 8'h00;
  localparam logic [7:0] DDAC_SYSCFG_RST   = 8'h00;

  localparam int DDAC_BIT_MODE8  = 7;
  localparam int DDAC_BIT_SPAN1  = 6;
  localparam int DDAC_BIT_SPAN0  = 5;
  localparam int DDAC_BIT_ZERON1 = 4;
  localparam int DDAC_BIT_ZERON0 = 3;
  localparam int DDAC_BIT_SYNC   = 2;
  localparam int DDAC_BIT_PWR1   = 1;
  localparam int DDAC_BIT_PWR0   = 0;
  localparam int DDAC_BIT_BYPASS = 5;

  localparam int DDAC_CODE_W = 12;
  localparam logic [11:0] DDAC_CODE_ZERO = 12'h000;
  localparam logic [3:0]  DDAC_PAD_ZERO  = 4'h0;
endpackage

// *** core/ddac_channel.sv ***
// one converter channel: held code, output code, zero forcing and power gating
`timescale 1ns/1ps
module ddac_channel
  import ddac_pkg::*;
(
  input  wire logic                   ref_clk,       // core clock
  input  wire logic                   rst_n,         // sync reset, active low
  input  wire logic [7:0]             code_low_q,    // low code byte register
  input  wire logic [7:0]             code_high_q,   // high code byte register
  input  wire logic                   mode8,         // 8-bit mode select
  input  wire logic                   load,          // transfer held code to output
  input  wire logic                   output_zero_n, // low forces zero output
  input  wire logic                   power_on,      // channel powered
  output logic [DDAC_CODE_W-1:0]      dac_code,      // code to converter core
  output logic                        dac_enable,    // output driven (else high impedance)
  output logic                        dac_zero       // output forced to 0 V
);
  logic [DDAC_CODE_W-1:0] held_code;
  logic [DDAC_CODE_W-1:0] out_code_q;
  logic [DDAC_CODE_W-1:0] out_code_d;

  assign held_code  = mode8 ? {code_low_q, DDAC_PAD_ZERO}
                            : {code_high_q[3:0], code_low_q};
  assign out_code_d = load ? held_code : out_code_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      out_code_q <= DDAC_CODE_ZERO;
      dac_enable <= 1'b0;
      dac_zero   <= 1'b1;
      dac_code   <= DDAC_CODE_ZERO;
    end else begin
      out_code_q <= out_code_d;
      dac_enable <= power_on;
      dac_zero   <= ~output_zero_n;
      dac_code   <= output_zero_n ? out_code_d : DDAC_CODE_ZERO;
    end
  end
endmodule

// *** core/ddac_top.sv ***
// top: classic wishbone register file and update control for two 12-bit converters
//
// Functional notes
// - control bit 7 selects 8-bit mode
// - bit 6 selects channel 1 span
// - bit 5 selects channel 0 span
// - bit 4 low zeroes channel 1
// - bit 3 low zeroes channel 0
// - sync high: low byte write updates output
// - sync low holds; rising sync loads both
// - bit 1 powers channel 1
// - bit 0 powers channel 0
// - 12-bit code right-justified in byte pair
// - data byte registers reset to zero
// - converters disabled, high impedance after reset
// - configuration bit 5 bypasses output buffer
`timescale 1ns/1ps
module ddac_top
  import ddac_pkg::*;
(
  input  wire logic                   ref_clk,       // core clock, 100 MHz
  input  wire logic                   rst_n,         // sync reset, active low
  input  wire logic                   wb_cyc_i,      // wishbone cycle
  input  wire logic                   wb_stb_i,      // wishbone strobe
  input  wire logic                   wb_we_i,       // wishbone write enable
  input  wire logic [7:0]             wb_adr_i,      // wishbone byte address
  input  wire logic [3:0]             wb_sel_i,      // wishbone byte selects
  input  wire logic [31:0]            wb_dat_i,      // wishbone write data
  output logic [31:0]                 wb_dat_o,      // wishbone read data
  output logic                        wb_ack_o,      // wishbone acknowledge
  output logic                        wb_err_o,      // unmapped address answer
  output logic [DDAC_CODE_W-1:0]      dac0_code,     // channel 0 output code
  output logic [DDAC_CODE_W-1:0]      dac1_code,     // channel 1 output code
  output logic                        dac0_enable,   // channel 0 driven
  output logic                        dac1_enable,   // channel 1 driven
  output logic                        dac0_zero,     // channel 0 forced to 0 V
  output logic                        dac1_zero,     // channel 1 forced to 0 V
  output logic                        span_select_ch0, // channel 0 supply span
  output logic                        span_select_ch1, // channel 1 supply span
  output logic                        buffer_bypass  // output buffer bypassed
);
  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [7:0] channel0_code_low_q;
  logic [7:0] channel0_code_high_q;
  logic [7:0] channel1_code_low_q;
  logic [7:0] channel1_code_high_q;
  logic [7:0] converter_control_q;
  logic [7:0] system_configuration_q;
  logic       sync_prev_q;
  logic       imm_load_ch0_q;
  logic       imm_load_ch1_q;
  // per-register next values
  logic [7:0] channel0_code_low_d;
  logic [7:0] channel0_code_high_d;
  logic [7:0] channel1_code_low_d;
  logic [7:0] channel1_code_high_d;
  logic [7:0] converter_control_d;
  logic [7:0] system_configuration_d;

  // ----------------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------------
  // address compare, shared by every register select
  function automatic logic ddac_hit(input logic [7:0] adr, input logic [7:0] ofs);
    return (adr == ofs);
  endfunction

  // next value of a byte register: new byte on its write strobe, else hold
  function automatic logic [7:0] ddac_byte_next(input logic wr_en, input logic [7:0] wdat, input logic [7:0] cur);
    return wr_en ? wdat : cur;
  endfunction

  // immediate update request of one channel
  function automatic logic ddac_imm_load(input logic sync, input logic low_wr);
    return sync & low_wr;
  endfunction

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  // a request is taken only while no answer stands, so each gets exactly one
  // sel[0] gates every write; the other byte lanes are ignored
  wire req      = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire hit_c0l  = ddac_hit(wb_adr_i, DDAC_OFS_CH0_LOW);
  wire hit_c0h  = ddac_hit(wb_adr_i, DDAC_OFS_CH0_HIGH);
  wire hit_c1l  = ddac_hit(wb_adr_i, DDAC_OFS_CH1_LOW);
  wire hit_c1h  = ddac_hit(wb_adr_i, DDAC_OFS_CH1_HIGH);
  wire hit_ctl  = ddac_hit(wb_adr_i, DDAC_OFS_CONTROL);
  wire hit_cfg  = ddac_hit(wb_adr_i, DDAC_OFS_SYSCFG);
  wire hit_sts  = ddac_hit(wb_adr_i, DDAC_OFS_STATUS);
  wire mapped   = hit_c0l | hit_c0h | hit_c1l | hit_c1h | hit_ctl | hit_cfg | hit_sts;
  wire wr       = req & wb_we_i & wb_sel_i[0] & mapped;
  wire wr_c0l   = wr & hit_c0l;
  wire wr_c0h   = wr & hit_c0h;
  wire wr_c1l   = wr & hit_c1l;
  wire wr_c1h   = wr & hit_c1h;
  wire wr_ctl   = wr & hit_ctl;
  wire wr_cfg   = wr & hit_cfg;
  wire [7:0] wdata = wb_dat_i[7:0];

  // status: live state of both channels
  wire [7:0] status_byte = {4'h0, dac1_zero, dac0_zero, dac1_enable, dac0_enable};

  wire [7:0] rd_byte = hit_c0l ? channel0_code_low_q    :
                       hit_c0h ? channel0_code_high_q   :
                       hit_c1l ? channel1_code_low_q    :
                       hit_c1h ? channel1_code_high_q   :
                       hit_ctl ? converter_control_q    :
                       hit_cfg ? system_configuration_q :
                       hit_sts ? status_byte            : 8'h00;

  // ----------------------------------------------------------------------
  // update control
  // ----------------------------------------------------------------------
  // control fields
  wire mode8      = converter_control_q[DDAC_BIT_MODE8];
  wire span_ch1   = converter_control_q[DDAC_BIT_SPAN1];
  wire span_ch0   = converter_control_q[DDAC_BIT_SPAN0];
  wire zero_n_ch1 = converter_control_q[DDAC_BIT_ZERON1];
  wire zero_n_ch0 = converter_control_q[DDAC_BIT_ZERON0];
  wire pwr_ch1    = converter_control_q[DDAC_BIT_PWR1];
  wire pwr_ch0    = converter_control_q[DDAC_BIT_PWR0];
  wire sync_now   = converter_control_q[DDAC_BIT_SYNC];
  wire bypass_sel = system_configuration_q[DDAC_BIT_BYPASS];

  // a low byte is stored at its write edge, so the immediate load waits one
  // cycle and then copies the freshly stored byte pair
  wire imm_load_ch0_d = ddac_imm_load(sync_now, wr_c0l);
  wire imm_load_ch1_d = ddac_imm_load(sync_now, wr_c1l);
  wire sync_rise      = sync_now & ~sync_prev_q;
  wire load_ch0       = imm_load_ch0_q | sync_rise;
  wire load_ch1       = imm_load_ch1_q | sync_rise;

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  assign channel0_code_low_d    = ddac_byte_next(wr_c0l, wdata, channel0_code_low_q);
  assign channel0_code_high_d   = ddac_byte_next(wr_c0h, wdata, channel0_code_high_q);
  assign channel1_code_low_d    = ddac_byte_next(wr_c1l, wdata, channel1_code_low_q);
  assign channel1_code_high_d   = ddac_byte_next(wr_c1h, wdata, channel1_code_high_q);
  assign converter_control_d    = ddac_byte_next(wr_ctl, wdata, converter_control_q);
  assign system_configuration_d = ddac_byte_next(wr_cfg, wdata, system_configuration_q);

  // data bytes clear at power-on; a write lands only in the byte it addresses
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      channel0_code_low_q <= DDAC_CODE_RST;
    end else begin
      channel0_code_low_q <= channel0_code_low_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      channel0_code_high_q <= DDAC_CODE_RST;
    end else begin
      channel0_code_high_q <= channel0_code_high_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      channel1_code_low_q <= DDAC_CODE_RST;
    end else begin
      channel1_code_low_q <= channel1_code_low_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      channel1_code_high_q <= DDAC_CODE_RST;
    end else begin
      channel1_code_high_q <= channel1_code_high_d;
    end
  end

  // control resets with sync set and both channels powered down
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      converter_control_q <= DDAC_CONTROL_RST;
    end else begin
      converter_control_q <= converter_control_d;
    end
  end

  // system configuration: only the bypass bit acts, every bit reads back
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      system_configuration_q <= DDAC_SYSCFG_RST;
    end else begin
      system_configuration_q <= system_configuration_d;
    end
  end

  // previous sync level starts at its reset value, so reset gives no false rise
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync_prev_q <= DDAC_CONTROL_RST[DDAC_BIT_SYNC];
    end else begin
      sync_prev_q <= sync_now;
    end
  end

  // one-cycle immediate load request of each channel
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      imm_load_ch0_q <= 1'b0;
    end else begin
      imm_load_ch0_q <= imm_load_ch0_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      imm_load_ch1_q <= 1'b0;
    end else begin
      imm_load_ch1_q <= imm_load_ch1_d;
    end
  end

  // ----------------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------------
  // answer one cycle after the request; read byte only in a read acknowledge
  wire        ack_d = req & mapped;
  wire        err_d = req & ~mapped;
  wire [31:0] dat_d = (ack_d & ~wb_we_i) ? {24'h000000, rd_byte} : 32'h0000_0000;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end else begin
      wb_ack_o <= ack_d;
      wb_err_o <= err_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_dat_o <= dat_d;
    end
  end

  // ----------------------------------------------------------------------
  // static controls
  // ----------------------------------------------------------------------
  // span and bypass follow their register bits one cycle later
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      span_select_ch0 <= 1'b0;
      span_select_ch1 <= 1'b0;
    end else begin
      span_select_ch0 <= span_ch0;
      span_select_ch1 <= span_ch1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      buffer_bypass <= 1'b0;
    end else begin
      buffer_bypass <= bypass_sel;
    end
  end

  // ----------------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------------
  // both channels share the width mode; each has its own load, zero and power
  ddac_channel u_ch0 (
    .ref_clk       (ref_clk),
    .rst_n         (rst_n),
    .code_low_q    (channel0_code_low_q),
    .code_high_q   (channel0_code_high_q),
    .mode8         (mode8),
    .load          (load_ch0),
    .output_zero_n (zero_n_ch0),
    .power_on      (pwr_ch0),
    .dac_code      (dac0_code),
    .dac_enable    (dac0_enable),
    .dac_zero      (dac0_zero)
  );

  ddac_channel u_ch1 (
    .ref_clk       (ref_clk),
    .rst_n         (rst_n),
    .code_low_q    (channel1_code_low_q),
    .code_high_q   (channel1_code_high_q),
    .mode8         (mode8),
    .load          (load_ch1),
    .output_zero_n (zero_n_ch1),
    .power_on      (pwr_ch1),
    .dac_code      (dac1_code),
    .dac_enable    (dac1_enable),
    .dac_zero      (dac1_zero)
  );
endmodule

// *** tb/ddac_checker.sv ***
// checker: bus answers and output relations of the converter control block
`timescale 1ns/1ps
module ddac_checker
  import ddac_pkg::*;
(
  input wire logic        ref_clk,         // clock
  input wire logic        rst_n,           // reset
  input wire logic        wb_cyc_i,        // cycle
  input wire logic        wb_stb_i,        // strobe
  input wire logic        wb_we_i,         // write
  input wire logic [7:0]  wb_adr_i,        // address
  input wire logic [3:0]  wb_sel_i,        // selects
  input wire logic [31:0] wb_dat_i,        // wdata
  input wire logic [31:0] wb_dat_o,        // rdata
  input wire logic        wb_ack_o,        // ack
  input wire logic        wb_err_o,        // error
  input wire logic [11:0] dac0_code,       // code 0
  input wire logic [11:0] dac1_code,       // code 1
  input wire logic        dac0_enable,     // on 0
  input wire logic        dac1_enable,     // on 1
  input wire logic        dac0_zero,       // zero 0
  input wire logic        dac1_zero,       // zero 1
  input wire logic        span_select_ch0, // span 0
  input wire logic        span_select_ch1, // span 1
  input wire logic        buffer_bypass    // bypass
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire tk  = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire map = (wb_adr_i >= DDAC_OFS_CH0_LOW && wb_adr_i <= DDAC_OFS_CONTROL) || wb_adr_i == DDAC_OFS_SYSCFG
             || wb_adr_i == DDAC_OFS_STATUS;
  wire wr  = tk && wb_we_i && wb_sel_i[0];
  sequence ctl_taken; wr && wb_adr_i == DDAC_OFS_CONTROL ##1 wb_ack_o; endsequence
  sequence cfg_taken; wr && wb_adr_i == DDAC_OFS_SYSCFG ##1 wb_ack_o; endsequence
  chk_bus_answer: assert property (tk |=> wb_ack_o ^ wb_err_o) else $error("no single answer");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_err_unmapped: assert property (tk && !map |=> wb_err_o) else $error("no error answer");
  chk_read_idle: assert property (wb_dat_o[31:8] == 24'h0 && (wb_ack_o || wb_dat_o == 32'h0)) else $error("bad rdata");
  chk_ch0_ctl: assert property (ctl_taken |=> dac0_enable == $past(wb_dat_i[0], 2) &&
    dac0_zero == !$past(wb_dat_i[3], 2) && span_select_ch0 == $past(wb_dat_i[5], 2)) else $error("ch0 ctl");
  chk_ch1_ctl: assert property (ctl_taken |=> dac1_enable == $past(wb_dat_i[1], 2) &&
    dac1_zero == !$past(wb_dat_i[4], 2) && span_select_ch1 == $past(wb_dat_i[6], 2)) else $error("ch1 ctl");
  chk_buffer_bypass: assert property (cfg_taken |=> buffer_bypass == $past(wb_dat_i[5], 2)) else $error("bypass");
  chk_zero_code: assert property ((dac0_zero || dac1_zero) |-> (!dac0_zero || dac0_code == 12'h000) &&
    (!dac1_zero || dac1_code == 12'h000)) else $error("zero code");
  chk_code_cause: assert property (($changed(dac0_code) || $changed(dac1_code)) && $past(rst_n) |->
    $past(wr && wb_we_i, 2) || $past(wr && wb_we_i, 3)) else $error("code moved alone");
endmodule
bind ddac_top ddac_checker u_ddac_checker (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .dac0_code, .dac1_code, .dac0_enable, .dac1_enable, .dac0_zero,
  .dac1_zero, .span_select_ch0, .span_select_ch1, .buffer_bypass);

// *** tb/test_dual_dac_control_interface.sv ***
// testbench: random register traffic checked against a reference model
`timescale 1ns/1ps
module test_dual_dac_control_interface;
  import ddac_pkg::*;
  logic        ref_clk, rst_n = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, er;
  logic [7:0]  wb_adr_i = 8'h00, a, c, mem [256];
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r, rd, ex, gt;
  logic [11:0] dac0_code, dac1_code, oq [2];
  logic        wb_ack_o, wb_err_o, dac0_enable, dac1_enable, dac0_zero, dac1_zero;
  logic        span_select_ch0, span_select_ch1, buffer_bypass;
  logic [7:0]  adrs [8] = '{8'hF9, 8'hFA, 8'hFB, 8'hFC, 8'hFD, 8'hAF, 8'h10, 8'hF8};
  logic [7:0]  dir_adr [9] = '{8'hFD, 8'hFA, 8'hF9, 8'hFD, 8'hFC, 8'hFB, 8'hFD, 8'hFD, 8'hFB};
  logic [7:0]  dir_dat [9] = '{8'h1F, 8'h0B, 8'h34, 8'h1B, 8'h05, 8'h67, 8'h1F, 8'h9F, 8'hA5};
  int          seed = 9264, miscompares = 0, tests_run = 0, cycles = 0;
  ddac_top u_ddac_top (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .wb_err_o, .dac0_code, .dac1_code, .dac0_enable, .dac1_enable, .dac0_zero,
    .dac1_zero, .span_select_ch0, .span_select_ch1, .buffer_bypass);
  function automatic logic mapped(input logic [7:0] x);
    return (x >= DDAC_OFS_CH0_LOW && x <= DDAC_OFS_CONTROL) || x == DDAC_OFS_SYSCFG || x == DDAC_OFS_STATUS;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic load(input int ch);
    c = mem[DDAC_OFS_CONTROL];
    oq[ch] = c[7] ? {mem[249 + 2 * ch], 4'h0} : {mem[250 + 2 * ch][3:0], mem[249 + 2 * ch]};
  endtask
  task automatic bus(input logic w, input logic [3:0] s, input logic [7:0] d);
    @(posedge ref_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= {r[31:8], d};
    do @(posedge ref_clk); while (!(wb_ack_o || wb_err_o));
    rd = wb_dat_o;
    er = wb_err_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task automatic outchk();
    repeat (2) @(negedge ref_clk);
    c  = mem[DDAC_OFS_CONTROL];
    ex = {1'h0, c[4] ? oq[1] : 12'h000, c[3] ? oq[0] : 12'h000, c[1], c[0], !c[4], !c[3], c[6], c[5], mem[175][5]};
    gt = {1'h0, dac1_code, dac0_code, dac1_enable, dac0_enable, dac1_zero, dac0_zero, span_select_ch1,
          span_select_ch0, buffer_bypass};
    chk("outputs", ex, gt);
  endtask
  task automatic wr(input logic [3:0] s, input logic [7:0] d);
    logic old;
    old = mem[DDAC_OFS_CONTROL][2];
    bus(1'h1, s, d);
    chk("write err", {31'h0, !mapped(a)}, {31'h0, er});
    if (s[0] && mapped(a) && a != DDAC_OFS_STATUS) mem[a] = d;
    c = mem[DDAC_OFS_CONTROL];
    if (!old && c[2]) begin
      load(0);
      load(1);
    end
    if (s[0] && c[2] && (a == DDAC_OFS_CH0_LOW || a == DDAC_OFS_CH1_LOW)) load(int'(a[1]));
    outchk();
  endtask
  task automatic rdchk();
    c = mem[DDAC_OFS_CONTROL];
    bus(1'h0, 4'hF, 8'h00);
    ex = !mapped(a) ? 32'h0 : (a == DDAC_OFS_STATUS ? {28'h0, !c[4], !c[3], c[1], c[0]} : {24'h0, mem[a]});
    chk("read data", ex, rd);
    chk("read err", {31'h0, !mapped(a)}, {31'h0, er});
  endtask
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    foreach (mem[i]) mem[i] = DDAC_CODE_RST;
    mem[DDAC_OFS_CONTROL] = DDAC_CONTROL_RST;
    oq = '{12'h000, 12'h000};
    r = 32'h0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'h1;
    outchk();
    for (int i = 0; i < 8; i++) begin
      a = adrs[i];
      rdchk();
    end
    for (int i = 0; i < 9; i++) begin
      a = dir_adr[i];
      wr(4'h1, dir_dat[i]);
    end
    for (int i = 0; i < 300; i++) begin
      r = $random(seed);
      a = adrs[r[2:0] % 7];
      if (a == DDAC_OFS_SYSCFG && (mem[DDAC_OFS_CONTROL][5] || mem[DDAC_OFS_CONTROL][6])) r[13] = 1'h0;
      if (a == DDAC_OFS_CONTROL && mem[DDAC_OFS_SYSCFG][5]) r[14:13] = 2'h0;
      wr(r[19:16] | {3'h0, r[20]}, r[15:8]);
      a = adrs[r[26:24]];
      rdchk();
    end
    end_of_test();
  end
endmodule
